// [logic/pcu_perf_counters.sv]
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module pcu_perf_counters
(
	input  wire logic                          clk,
	input  wire logic                          rstn,
	input  wire logic                          clk_en,
	input  wire pcu_pkg::pcu_reg_req_t         reg_req,
	output logic [pcu_pkg::DATA_W-1:0]         reg_rdata,
	input  wire pcu_pkg::pcu_cpu_evt_t         cpu_evt,
	input  wire logic [pcu_pkg::EVT_CH-1:0]    evt_hit,
	output logic [pcu_pkg::NUM_CH-1:0]         measuring
);
	import pcu_pkg::*;

	typedef enum logic [1:0] {
		PH_IDLE,
		PH_ARMED,
		PH_DONE
	} pcu_phase_t;

	pcu_cfg_t                 cfg_q     [NUM_CH];
	logic [CNT_W-1:0]         cnt_q     [NUM_CH];
	pcu_phase_t               phase_q   [NUM_CH];
	pcu_phase_t               phase_d   [NUM_CH];
	logic [NUM_CH-1:0]        start_hit;
	logic [NUM_CH-1:0]        end_hit;
	logic [NUM_CH-1:0]        cfg_wr;
	logic [NUM_CH-1:0]        free_mode;
	logic [NUM_CH-1:0]        one_sided;
	logic [NUM_CH-1:0]        inc;
	logic                     running_q;
	logic                     run_start;
	logic                     any_hit;
	logic [DATA_W-1:0]        rdata_d;
	logic [DATA_W-1:0]        rdata_q;

	// Returns whether the selected event-condition channel fires for this measurement channel.
	function automatic logic trig_fire(input logic [SEL_W-1:0] sel, input int ch, input logic [EVT_CH-1:0] hits);
		logic ok;
		ok = (sel != SEL_NONE) && (sel != SEL_EXCLUDED) && (sel <= SEL_MAX);
		// Channels one and two cannot take the two narrow sources.
		if ((ch < 2) && ((sel == SEL_NARROW_A) || (sel == SEL_NARROW_B)))
		begin
			ok = 1'b0;
		end
		// The hit vector is only indexed for a legal code, so no select runs past its top.
		trig_fire = 1'b0;
		if (ok)
		begin
			trig_fire = hits[sel - 4'h1];
		end
	endfunction

	// Returns whether the chosen item sees an event this cycle.
	function automatic logic item_event(input logic [ITEM_W-1:0] item, input pcu_cpu_evt_t e, input logic hit);
		case (item)
			ITEM_ELAPSED_CYCLE:        item_event = e.running;
			ITEM_PRIVILEGED_CYCLE:     item_event = e.running & e.privileged;
			ITEM_BLOCK_BIT_CYCLE:      item_event = e.running & e.exception_block_bit;
			ITEM_INSTRUCTION:          item_event = e.instr_done;
			ITEM_DUAL_ISSUE:           item_event = e.dual_issue;
			ITEM_UNCONDITIONAL_BRANCH: item_event = (e.uncond_branch & ~e.branch_by_exception) |
			                                        e.return_from_exception;
			ITEM_ACCEPTED_EXCEPTION:   item_event = e.exception_accepted | e.interrupt_accepted |
			                                        e.nmi_accepted;
			ITEM_ACCEPTED_INTERRUPT:   item_event = e.interrupt_accepted | e.nmi_accepted;
			ITEM_BREAK_CHANNEL_HIT:    item_event = hit;
			// Codes above the hit item count nothing.
			default:                   item_event = 1'b0;
		endcase
	endfunction

	// Byte address of a channel register.
	function automatic logic [ADDR_W-1:0] ch_addr(input logic [ADDR_W-1:0] base, input int ch);
		ch_addr = base + ADDR_W'(ch) * OFS_STRIDE;
	endfunction

	assign any_hit   = |evt_hit;
	// The run register resets low, the idle level of running, so no false start follows reset.
	assign run_start = cpu_evt.running & ~running_q;

	// Remembers the run level so a program start shows as a rising edge.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			running_q <= 1'b0;
		end
		else if (clk_en)
		begin
			running_q <= cpu_evt.running;
		end
	end

	// Per-channel trigger decode, shared by the phase machine and the counter.
	always_comb
	begin
		for (int ch = 0; ch < NUM_CH; ch++)
		begin
			cfg_wr[ch]    = reg_req.wr && (reg_req.addr == ch_addr(OFS_CFG0, ch));
			free_mode[ch] = (cfg_q[ch].start_sel == SEL_NONE) && (cfg_q[ch].end_sel == SEL_NONE);
			one_sided[ch] = (cfg_q[ch].start_sel == SEL_NONE) != (cfg_q[ch].end_sel == SEL_NONE);
			if (free_mode[ch])
			begin
				start_hit[ch] = run_start;
				end_hit[ch]   = any_hit;
			end
			else if (one_sided[ch])
			begin
				start_hit[ch] = 1'b0;
				end_hit[ch]   = 1'b0;
			end
			else
			begin
				start_hit[ch] = trig_fire(cfg_q[ch].start_sel, ch, evt_hit);
				end_hit[ch]   = trig_fire(cfg_q[ch].end_sel, ch, evt_hit);
			end
		end
	end

	// item selection storage
	// Only a software write changes a channel's configuration.
	// Only exact word addresses select a channel; other offsets in the range are ignored.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int ch = 0; ch < NUM_CH; ch++)
			begin
				cfg_q[ch] <= CFG_RESET;
			end
		end
		else if (clk_en)
		begin
			for (int ch = 0; ch < NUM_CH; ch++)
			begin
				if (cfg_wr[ch])
				begin
					cfg_q[ch].item      <= reg_req.wdata[CFG_ITEM_LSB +: ITEM_W];
					cfg_q[ch].start_sel <= reg_req.wdata[CFG_START_LSB +: SEL_W];
					cfg_q[ch].end_sel   <= reg_req.wdata[CFG_END_LSB +: SEL_W];
				end
			end
		end
	end

	// own start and end
	// A start that arrives while armed restarts the measurement; an end only stops an armed channel.
	always_comb
	begin
		for (int ch = 0; ch < NUM_CH; ch++)
		begin
			phase_d[ch] = phase_q[ch];
			case (phase_q[ch])
				PH_IDLE:
				begin
					if (start_hit[ch])
					begin
						phase_d[ch] = PH_ARMED;
					end
				end
				PH_ARMED:
				begin
					if (start_hit[ch])
					begin
						phase_d[ch] = PH_ARMED;
					end
					else if (end_hit[ch])
					begin
						phase_d[ch] = PH_DONE;
					end
				end
				PH_DONE:
				begin
					if (start_hit[ch])
					begin
						phase_d[ch] = PH_ARMED;
					end
				end
				default:
				begin
					phase_d[ch] = PH_IDLE;
				end
			endcase
			// Rewriting the configuration restarts the channel from idle.
			if (cfg_wr[ch])
			begin
				phase_d[ch] = PH_IDLE;
			end
		end
	end

	// Each channel keeps its own phase, so all four measure side by side.
	// four parallel channels
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int ch = 0; ch < NUM_CH; ch++)
			begin
				phase_q[ch] <= PH_IDLE;
			end
		end
		else if (clk_en)
		begin
			for (int ch = 0; ch < NUM_CH; ch++)
			begin
				phase_q[ch] <= phase_d[ch];
			end
		end
	end

	// An event only counts while its channel is armed; measuring mirrors the armed phase.
	// disabled counts nothing
	always_comb
	begin
		for (int ch = 0; ch < NUM_CH; ch++)
		begin
			inc[ch] = (phase_q[ch] == PH_ARMED) && item_event(cfg_q[ch].item, cpu_evt, any_hit);
			measuring[ch] = (phase_q[ch] == PH_ARMED);
		end
	end

	// exact at breaks
	// The counter wraps silently; software must sample long runs before the wrap.
	// Counts are exact to the cycle, so any slack around a break is left for software to allow.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int ch = 0; ch < NUM_CH; ch++)
			begin
				cnt_q[ch] <= '0;
			end
		end
		else if (clk_en)
		begin
			for (int ch = 0; ch < NUM_CH; ch++)
			begin
				if (cfg_wr[ch] || start_hit[ch])
				begin
					cnt_q[ch] <= '0;
				end
				else if (inc[ch])
				begin
					cnt_q[ch] <= cnt_q[ch] + CNT_W'(1);
				end
			end
		end
	end

	// Read decode; unmapped addresses read as zero.
	always_comb
	begin
		rdata_d = '0;
		for (int ch = 0; ch < NUM_CH; ch++)
		begin
			if (reg_req.addr == ch_addr(OFS_CFG0, ch))
			begin
				rdata_d = DATA_W'({cfg_q[ch].end_sel, cfg_q[ch].start_sel, cfg_q[ch].item});
			end
			if (reg_req.addr == ch_addr(OFS_CNT0, ch))
			begin
				rdata_d = cnt_q[ch];
			end
			if (reg_req.addr == OFS_STATUS)
			begin
				rdata_d[STAT_ARMED_LSB + ch] = (phase_q[ch] == PH_ARMED);
				rdata_d[STAT_DONE_LSB + ch]  = (phase_q[ch] == PH_DONE);
				rdata_d[STAT_BAD_LSB + ch]   = one_sided[ch];
			end
		end
	end

	// Read data stand only in the cycle after the strobe.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rdata_q <= '0;
		end
		else if (clk_en)
		begin
			rdata_q <= reg_req.rd ? rdata_d : '0;
		end
	end

	// Read data leave straight from the register, so the port never glitches.
	assign reg_rdata = rdata_q;

endmodule

// [logic/pcu_pkg.sv]
// Behaviour
// - Four channels each pick their own event class and all of them count at the same time.
// - Every channel has its own start trigger and end trigger taken from the event-condition channels.
// - Event-condition channels 1 to 6 and 8 to 12 may act as triggers, while channel 7 never does.
// - Event-condition channels 8 and 9 never trigger measurement channels one and two but do trigger three and four.
// - A channel with no triggers starts counting when the program starts running and stops on any event hit.
// - The disabled item never counts and the elapsed-cycle item counts every running CPU cycle.
// - The privileged-cycle item counts running cycles spent in privileged mode.
// - The block-bit item counts running cycles in which the exception-blocking status bit is one.
// - The instruction item counts completed instructions, so executed instructions equal it plus dual issues.
// - The dual-issue item counts each time two completed instructions were executed together.
// - The branch item counts unconditional branches not caused by exceptions, and also returns from exception.
// - The exception item counts accepted exceptions and interrupts, and the interrupt item counts interrupts and NMIs.
// - The hit item adds one in each cycle with any event-condition hit, simultaneous hits being ORed.
// - Counts are exact to the cycle around a break, so any tolerance is left for software and checks to allow.
package pcu_pkg;

	localparam int NUM_CH = 4;
	localparam int EVT_CH = 12;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CNT_W  = 32;
	localparam int SEL_W  = 4;
	localparam int ITEM_W = 4;

	// Register offsets in bytes; channel registers repeat at the stride.
	localparam logic [ADDR_W-1:0] OFS_CFG0   = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CNT0   = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_STRIDE = 8'h04;

	// Field positions in the configuration word.
	localparam int CFG_ITEM_LSB  = 0;
	localparam int CFG_START_LSB = 4;
	localparam int CFG_END_LSB   = 8;

	// Field positions in the status word.
	localparam int STAT_ARMED_LSB = 0;
	localparam int STAT_DONE_LSB  = 4;
	localparam int STAT_BAD_LSB   = 8;

	// Trigger selection codes.
	localparam logic [SEL_W-1:0] SEL_NONE     = 4'h0;
	localparam logic [SEL_W-1:0] SEL_EXCLUDED = 4'h7;
	localparam logic [SEL_W-1:0] SEL_NARROW_A = 4'h8;
	localparam logic [SEL_W-1:0] SEL_NARROW_B = 4'h9;
	localparam logic [SEL_W-1:0] SEL_MAX      = 4'hC;

	// Count item codes, in order from 0.
	typedef enum logic [ITEM_W-1:0] {
		ITEM_DISABLED,
		ITEM_ELAPSED_CYCLE,
		ITEM_PRIVILEGED_CYCLE,
		ITEM_BLOCK_BIT_CYCLE,
		ITEM_INSTRUCTION,
		ITEM_DUAL_ISSUE,
		ITEM_UNCONDITIONAL_BRANCH,
		ITEM_ACCEPTED_EXCEPTION,
		ITEM_ACCEPTED_INTERRUPT,
		ITEM_BREAK_CHANNEL_HIT
	} pcu_item_t;

	typedef struct packed {
		logic [SEL_W-1:0]  end_sel;
		logic [SEL_W-1:0]  start_sel;
		logic [ITEM_W-1:0] item;
	} pcu_cfg_t;

	localparam pcu_cfg_t CFG_RESET = '{end_sel: SEL_NONE, start_sel: SEL_NONE, item: 4'h0};

	typedef struct packed {
		logic running;
		logic privileged;
		logic exception_block_bit;
		logic instr_done;
		logic dual_issue;
		logic uncond_branch;
		logic branch_by_exception;
		logic return_from_exception;
		logic exception_accepted;
		logic interrupt_accepted;
		logic nmi_accepted;
	} pcu_cpu_evt_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} pcu_reg_req_t;

endpackage

// [sim/pcu_sva.sv]
`timescale 1ns/1ns
module pcu_sva
(
	input wire logic                       clk,
	input wire logic                       rstn,
	input wire logic                       clk_en,
	input wire pcu_pkg::pcu_reg_req_t      reg_req,
	input wire logic [pcu_pkg::DATA_W-1:0] reg_rdata,
	input wire logic [pcu_pkg::EVT_CH-1:0] evt_hit,
	input wire logic [pcu_pkg::NUM_CH-1:0] measuring
);
	import pcu_pkg::*;
	pcu_cfg_t          cfg_q [NUM_CH];
	logic [NUM_CH-1:0] go, stop, free;
	logic              rd_ok;
	assign rd_ok = clk_en && reg_req.rd;
	// Shadow of the setups, so that trigger picks can be predicted.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			cfg_q <= '{default: CFG_RESET};
		else if (clk_en && reg_req.wr && reg_req.addr < OFS_CNT0 && reg_req.addr[1:0] == 2'b00)
			cfg_q[reg_req.addr[3:2]] <= reg_req.wdata[11:0];
	end
	// A pick fires only if it is legal for this channel.
	function automatic logic fires(logic [SEL_W-1:0] s, int c);
		return s != SEL_NONE && s <= SEL_MAX && s != SEL_EXCLUDED && evt_hit[s-1]
			&& !(c < 2 && (s == SEL_NARROW_A || s == SEL_NARROW_B));
	endfunction
	// A start needs a paired end pick, since a lone trigger must never arm.
	always_comb
		for (int c = 0; c < NUM_CH; c++)
		begin
			go[c] = cfg_q[c].end_sel != SEL_NONE && fires(cfg_q[c].start_sel, c);
			stop[c] = fires(cfg_q[c].end_sel, c);
			free[c] = cfg_q[c].start_sel == SEL_NONE && cfg_q[c].end_sel == SEL_NONE;
		end
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// Register answers.
	a_rdata_idle:
		assert property (clk_en && !reg_req.rd |=> reg_rdata == '0) else $error("stray read data");
	a_cfg_readback:
		assert property (rd_ok && reg_req.addr < OFS_CNT0 |=> reg_rdata == DATA_W'(cfg_q[$past(reg_req.addr[3:2])]))
			else $error("setup readback");
	a_hole_zero:
		assert property (rd_ok && reg_req.addr > OFS_STATUS |=> reg_rdata == '0) else $error("hole read");
	a_status_armed:
		assert property (rd_ok && reg_req.addr == OFS_STATUS |=> reg_rdata[3:0] == $past(measuring))
			else $error("armed bits");
	// Arming and stopping of each channel.
	for (genvar c = 0; c < NUM_CH; c++)
	begin : g_ch
		sequence s_go;
			clk_en && go[c] && !reg_req.wr;
		endsequence
		a_start_arms:
			assert property (s_go |=> measuring[c]) else $error("no arm");
		a_end_stops:
			assert property (clk_en && measuring[c] && stop[c] && !go[c] && !reg_req.wr |=> !measuring[c])
				else $error("no stop");
		a_arm_cause:
			assert property ($rose(measuring[c]) && !free[c] |-> $past(clk_en) && $past(go[c])) else $error("bad arm");
		a_free_stop:
			assert property (clk_en && free[c] && measuring[c] && |evt_hit && !reg_req.wr |=> !measuring[c])
				else $error("free no stop");
		a_cfg_idles:
			assert property (clk_en && reg_req.wr && reg_req.addr == 8'(4 * c) |=> !measuring[c])
				else $error("write kept arm");
	end
endmodule
bind pcu_perf_counters pcu_sva u_pcu_sva (.clk(clk), .rstn(rstn), .clk_en(clk_en), .reg_req(reg_req),
	.reg_rdata(reg_rdata), .evt_hit(evt_hit), .measuring(measuring));

// [sim/pcu_cpu_model.sv]
`timescale 1ns/1ns
module pcu_cpu_model
(
	input wire logic                       clk,
	input wire logic                       rstn,
	input wire pcu_pkg::pcu_cpu_evt_t      req,
	input wire logic [pcu_pkg::EVT_CH-1:0] hit_req,
	output pcu_pkg::pcu_cpu_evt_t          cpu_evt,
	output logic [pcu_pkg::EVT_CH-1:0]     evt_hit
);
	import pcu_pkg::*;
	// Core events leave from flops, so each request shows one cycle later.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cpu_evt <= '0;
			evt_hit <= '0;
		end
		else
		begin
			cpu_evt <= req;
			// A pair can only retire beside a completed instruction.
			cpu_evt.dual_issue <= req.dual_issue & req.instr_done;
			evt_hit <= hit_req;
		end
	end
endmodule

// [sim/tb_pcu_perf_counters.sv]
`timescale 1ns/1ns
module tb_pcu_perf_counters;
	import pcu_pkg::*;
	logic              clk = 1'b0;
	logic              rstn = 1'b0;
	logic              clk_en = 1'b1;
	pcu_reg_req_t      reg_req = '0;
	logic [DATA_W-1:0] reg_rdata, v, w;
	pcu_cpu_evt_t      lv = '0, evt_req = '0, cpu_evt;
	logic [EVT_CH-1:0] hit_req = '0, evt_hit;
	logic [NUM_CH-1:0] measuring;
	int                num_errors = 0;
	int                samples_checked = 0;
	// Window pattern: five event cycles; the count per item code follows from it.
	pcu_cpu_evt_t      pat [5] = '{11'h2C0, 11'h1A0, 11'h034, 11'h20E, 11'h081};
	logic [EVT_CH-1:0] pat_hit [5] = '{12'h0, 12'h050, 12'h0, 12'h0, 12'h0};
	int                exp_cnt [12] = '{0, 12, 2, 1, 3, 1, 2, 3, 2, 2, 0, 0};
	logic [7:0]        trg [4] = '{8'h21, 8'h21, 8'h98, 8'hAC};
	always #50 clk = ~clk;
	pcu_perf_counters u_pcu_perf_counters (.clk(clk), .rstn(rstn), .clk_en(clk_en), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .cpu_evt(cpu_evt), .evt_hit(evt_hit), .measuring(measuring));
	pcu_cpu_model u_pcu_cpu_model (.clk(clk), .rstn(rstn), .req(evt_req), .hit_req(hit_req),
		.cpu_evt(cpu_evt), .evt_hit(evt_hit));
	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			num_errors++;
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		reg_req.addr <= a;
		reg_req.wdata <= d;
		reg_req.wr <= 1'b1;
		@(posedge clk);
		reg_req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge clk);
		reg_req.addr <= a;
		reg_req.rd <= 1'b1;
		@(posedge clk);
		reg_req.rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	// One cycle of core events and hits on top of the level signals.
	task automatic pulse(input pcu_cpu_evt_t e, input logic [EVT_CH-1:0] h);
		@(posedge clk);
		evt_req <= lv | e;
		hit_req <= h;
		@(posedge clk);
		evt_req <= lv;
		hit_req <= '0;
	endtask
	task automatic wrap_up;
		if (num_errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Main sequence; the design sees each core-event request one edge after it is issued, and each register request at once.
	initial
	begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		wr(OFS_CNT0, 32'hFFFFFFFF);
		for (int a = 0; a <= 9; a++)
		begin
			rd(8'(4 * a), v);
			chk(v, '0);
		end
		lv.running = 1'b1;
		pulse('0, '0);
		// Three runs give every item code a turn, all four channels at once.
		for (int r = 0; r < 3; r++)
		begin
			for (int c = 0; c < NUM_CH; c++)
			begin
				w = {20'h0, trg[c], 4'(4 * r + c)};
				wr(8'(4 * c), w);
				rd(8'(4 * c), v);
				chk(v, w);
			end
			pulse('0, 12'h881);
			for (int i = 0; i < 5; i++)
				pulse(pat[i], pat_hit[i]);
			pulse('0, 12'h302);
			for (int c = 0; c < NUM_CH; c++)
			begin
				rd(OFS_CNT0 + 8'(4 * c), v);
				chk(v, 32'(exp_cnt[4 * r + c]));
			end
			rd(OFS_STATUS, v);
			chk(v, 32'h000000F0);
		end
		// lone start pick on channel three, set up wrongly on purpose.
		wr(8'h00, 32'h00000981);
		wr(8'h04, 32'h00000271);
		wr(8'h08, 32'h00000011);
		wr(8'h0C, 32'h000002D1);
		pulse('0, 12'hFFF);
		@(posedge clk);
		#1;
		chk(32'(measuring), '0);
		rd(OFS_STATUS, v);
		chk(32'(v[7:0]), '0);
		chk(32'(v[11:8]), 32'h4);
		// Free mode waits for the run start; its edges may be off by one.
		lv.running = 1'b0;
		pulse('0, '0);
		wr(8'h00, 32'h00000001);
		lv.running = 1'b1;
		pulse('0, '0);
		repeat (7) @(posedge clk);
		#1;
		chk(32'(measuring[0]), 32'h1);
		pulse('0, 12'h001);
		rd(OFS_CNT0, v);
		chk(32'(v inside {[8:10]}), 32'h1);
		wrap_up;
	end
	// Cuts a hung run short; the sequence needs well under a thousand cycles.
	initial
	begin
		repeat (5000) @(posedge clk);
		num_errors++;
		wrap_up;
	end
endmodule
